//--- src/tmc_pkg.sv
// package: register map, field layout and decodes for the ch1/ch2 mode block
`default_nettype none
package tmc_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 16;
  localparam logic [7:0] OFS_MODE = 8'h18;
  localparam logic [7:0] OFS_ENABLE = 8'h20;
  localparam logic [7:0] OFS_CMP1 = 8'h34;
  localparam logic [7:0] OFS_CMP2 = 8'h38;
  localparam logic [7:0] OFS_STATUS = 8'h3C;
  localparam logic [15:0] MODE_RESET = 16'h0000;
  localparam logic [15:0] CMP_RESET = 16'h0000;
  // per-channel field positions; channel 2 sits CH_STRIDE bits higher
  localparam int unsigned CH_STRIDE = 8;
  localparam int unsigned SEL_LSB = 0;
  localparam int unsigned PSC_LSB = 2;
  localparam int unsigned FLT_LSB = 4;
  localparam int unsigned FEN_BIT = 2;
  localparam int unsigned PEN_BIT = 3;
  localparam int unsigned OCM_LSB = 4;
  localparam int unsigned RSV_BIT = 7;
  // enable bits of the channel enable register
  localparam int unsigned EN1_BIT = 0;
  localparam int unsigned EN2_BIT = 4;

  typedef enum logic [1:0] {
    DIR_OUT = 2'h0,
    DIR_OWN = 2'h1,
    DIR_OTHER = 2'h2,
    DIR_TRIG = 2'h3
  } tmc_dir_t;

  typedef enum logic [2:0] {
    OCM_FREEZE = 3'h0,
    OCM_SET = 3'h1,
    OCM_CLEAR = 3'h2,
    OCM_TOGGLE = 3'h3,
    OCM_LOW = 3'h4,
    OCM_HIGH = 3'h5,
    OCM_PWM1 = 3'h6,
    OCM_PWM2 = 3'h7
  } tmc_ocm_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } tmc_bus_req_t;

  typedef struct packed {
    logic [5:0] div;
    logic [3:0] n;
  } tmc_flt_t;

  function automatic tmc_flt_t tmc_flt_decode(input logic [3:0] code);
    tmc_flt_t f;
    f = '{div: 6'h01, n: 4'h1};
    unique case (code)
      4'h0: f = '{div: 6'h01, n: 4'h1};
      4'h1: f = '{div: 6'h01, n: 4'h2};
      4'h2: f = '{div: 6'h01, n: 4'h4};
      4'h3: f = '{div: 6'h01, n: 4'h8};
      4'h4: f = '{div: 6'h02, n: 4'h6};
      4'h5: f = '{div: 6'h02, n: 4'h8};
      4'h6: f = '{div: 6'h04, n: 4'h6};
      4'h7: f = '{div: 6'h04, n: 4'h8};
      4'h8: f = '{div: 6'h08, n: 4'h6};
      4'h9: f = '{div: 6'h08, n: 4'h8};
      4'hA: f = '{div: 6'h10, n: 4'h5};
      4'hB: f = '{div: 6'h10, n: 4'h6};
      4'hC: f = '{div: 6'h10, n: 4'h8};
      4'hD: f = '{div: 6'h20, n: 4'h5};
      4'hE: f = '{div: 6'h20, n: 4'h6};
      4'hF: f = '{div: 6'h20, n: 4'h8};
    endcase
    return f;
  endfunction : tmc_flt_decode
endpackage : tmc_pkg
`default_nettype wire

//--- src/tmc_ch12_mode.sv
// timer channel 1/2 mode configuration, input filter, capture and compare
`default_nettype none
module tmc_ch12_mode #(
  parameter int unsigned CNT_W = 16
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire tmc_pkg::tmc_bus_req_t bus_req,
  output logic [15:0] rdata,
  input wire logic timer_input_one,
  input wire logic timer_input_two,
  input wire logic internal_trigger_selection,
  input wire logic update_event,
  input wire logic [CNT_W-1:0] counter_value,
  output logic [1:0] capture_pulse,
  output logic [1:0] filtered_input,
  output logic [1:0] output_reference,
  output logic [1:0] fast_enable,
  output logic [1:0] channel_enable
);
  localparam int unsigned S = tmc_pkg::CH_STRIDE;

  logic [15:0] mode_r;
  logic [15:0] mode_nxt;
  logic [1:0] en_r;
  logic [1:0] en_nxt;
  logic [15:0] rdata_r;
  logic [15:0] rdata_nxt;
  logic [CNT_W-1:0] shd_r [2];
  logic [CNT_W-1:0] shd_nxt [2];
  logic [CNT_W-1:0] act_r [2];
  logic flt_r [2];
  logic ref_r [2];
  logic cap_r [2];
  logic tick [2];
  logic wr_cmp [2];
  logic pin [2];
  logic [1:0] en_wr;

  assign pin[0] = timer_input_one;
  assign pin[1] = timer_input_two;
  assign wr_cmp[0] = bus_req.wr && bus_req.addr == tmc_pkg::OFS_CMP1;
  assign wr_cmp[1] = bus_req.wr && bus_req.addr == tmc_pkg::OFS_CMP2;
  assign en_wr[0] = bus_req.wdata[tmc_pkg::EN1_BIT];
  assign en_wr[1] = bus_req.wdata[tmc_pkg::EN2_BIT];

  // register file
  always_comb begin
    mode_nxt = mode_r;
    en_nxt = en_r;
    rdata_nxt = 16'h0000;
    for (int c = 0; c < 2; c++) begin
      shd_nxt[c] = shd_r[c];
      if (wr_cmp[c]) begin
        shd_nxt[c] = bus_req.wdata[CNT_W-1:0];
      end
    end
    if (bus_req.wr && bus_req.addr == tmc_pkg::OFS_MODE) begin
      mode_nxt = bus_req.wdata;
      for (int c = 0; c < 2; c++) begin
        if (en_r[c]) begin
          mode_nxt[c*S+tmc_pkg::SEL_LSB +: 2] =
            mode_r[c*S+tmc_pkg::SEL_LSB +: 2];
        end
        if (mode_nxt[c*S+tmc_pkg::SEL_LSB +: 2] == tmc_pkg::DIR_OUT) begin
          mode_nxt[c*S+tmc_pkg::RSV_BIT] = 1'b0;
        end
      end
    end
    if (bus_req.wr && bus_req.addr == tmc_pkg::OFS_ENABLE) begin
      en_nxt = en_wr;
    end
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        tmc_pkg::OFS_MODE: rdata_nxt = mode_r;
        tmc_pkg::OFS_ENABLE: begin
          rdata_nxt[tmc_pkg::EN1_BIT] = en_r[0];
          rdata_nxt[tmc_pkg::EN2_BIT] = en_r[1];
        end
        tmc_pkg::OFS_CMP1: rdata_nxt[CNT_W-1:0] = act_r[0];
        tmc_pkg::OFS_CMP2: rdata_nxt[CNT_W-1:0] = act_r[1];
        tmc_pkg::OFS_STATUS: begin
          rdata_nxt[3:0] = {ref_r[1], ref_r[0], flt_r[1], flt_r[0]};
        end
        default: rdata_nxt = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      mode_r <= tmc_pkg::MODE_RESET;
      en_r <= 2'h0;
      rdata_r <= 16'h0000;
      shd_r[0] <= tmc_pkg::CMP_RESET[CNT_W-1:0];
      shd_r[1] <= tmc_pkg::CMP_RESET[CNT_W-1:0];
    end else begin
      mode_r <= mode_nxt;
      en_r <= en_nxt;
      rdata_r <= rdata_nxt;
      shd_r[0] <= shd_nxt[0];
      shd_r[1] <= shd_nxt[1];
    end
  end

  for (genvar g = 0; g < 2; g++) begin : g_ch
    tmc_pkg::tmc_dir_t dir;
    tmc_pkg::tmc_ocm_t ocm;
    tmc_pkg::tmc_flt_t fd;
    logic [1:0] prescale_factor;
    logic pen;
    logic src;
    logic hit;
    logic evt;
    logic [2:0] lim;
    logic [4:0] div_r;
    logic [4:0] div_nxt;
    logic [2:0] run_r;
    logic [2:0] run_nxt;
    logic flt_nxt;
    logic fltd_r;
    logic [2:0] pcnt_r;
    logic [2:0] pcnt_nxt;
    logic cap_nxt;
    logic [CNT_W-1:0] act_nxt;
    logic ref_nxt;
    logic hitd_r;

    // field bits change meaning with the direction select
    assign dir = tmc_pkg::tmc_dir_t'(mode_r[g*S+tmc_pkg::SEL_LSB +: 2]);
    assign prescale_factor = mode_r[g*S+tmc_pkg::PSC_LSB +: 2];
    assign fd = tmc_pkg::tmc_flt_decode(
      mode_r[g*S+tmc_pkg::FLT_LSB +: 4]);
    assign ocm = tmc_pkg::tmc_ocm_t'(
      mode_r[g*S+tmc_pkg::OCM_LSB +: 3]);
    assign pen = mode_r[g*S+tmc_pkg::PEN_BIT];
    // a divisor cut below the running count ticks at once, no wrap
    assign tick[g] = {1'b0, div_r} >= fd.div - 6'h01;
    assign hit = counter_value == act_r[g] && !hitd_r;
    assign evt = flt_r[g] && !fltd_r;
    assign lim = 3'((4'h1 << prescale_factor) - 4'h1);

    always_comb begin
      unique case (dir)
        tmc_pkg::DIR_OWN: src = pin[g];
        tmc_pkg::DIR_OTHER: src = pin[1-g];
        tmc_pkg::DIR_TRIG: src = internal_trigger_selection;
        tmc_pkg::DIR_OUT: src = 1'b0;
      endcase
    end

    always_comb begin
      div_nxt = tick[g] ? 5'h00 : div_r + 5'h01;
      run_nxt = run_r;
      flt_nxt = flt_r[g];
      if (tick[g]) begin
        if (src == flt_r[g]) begin
          run_nxt = 3'h0;
        end else if ({1'b0, run_r} + 4'h1 >= fd.n) begin
          flt_nxt = src;
          run_nxt = 3'h0;
        end else begin
          run_nxt = run_r + 3'h1;
        end
      end
      pcnt_nxt = pcnt_r;
      cap_nxt = 1'b0;
      if (dir == tmc_pkg::DIR_OUT || !en_r[g]) begin
        pcnt_nxt = 3'h0;
      end else if (evt) begin
        if (pcnt_r == lim) begin
          cap_nxt = 1'b1;
          pcnt_nxt = 3'h0;
        end else begin
          pcnt_nxt = pcnt_r + 3'h1;
        end
      end
      act_nxt = act_r[g];
      if (cap_nxt) begin
        act_nxt = counter_value;
      end else if (dir == tmc_pkg::DIR_OUT) begin
        if (!pen && wr_cmp[g]) begin
          act_nxt = bus_req.wdata[CNT_W-1:0];
        end else if (pen && update_event) begin
          act_nxt = wr_cmp[g] ? bus_req.wdata[CNT_W-1:0] : shd_r[g];
        end
      end
      ref_nxt = 1'b0;
      if (dir == tmc_pkg::DIR_OUT) begin
        unique case (ocm)
          tmc_pkg::OCM_FREEZE: ref_nxt = ref_r[g];
          tmc_pkg::OCM_SET: ref_nxt = hit || ref_r[g];
          tmc_pkg::OCM_CLEAR: ref_nxt = !hit && ref_r[g];
          tmc_pkg::OCM_TOGGLE: ref_nxt = hit ^ ref_r[g];
          tmc_pkg::OCM_LOW: ref_nxt = 1'b0;
          tmc_pkg::OCM_HIGH: ref_nxt = 1'b1;
          tmc_pkg::OCM_PWM1: ref_nxt = counter_value < act_r[g];
          tmc_pkg::OCM_PWM2: ref_nxt = counter_value > act_r[g];
        endcase
      end
    end

    always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
        div_r <= 5'h00;
        run_r <= 3'h0;
        flt_r[g] <= 1'b0;
        fltd_r <= 1'b0;
        pcnt_r <= 3'h0;
        cap_r[g] <= 1'b0;
        act_r[g] <= tmc_pkg::CMP_RESET[CNT_W-1:0];
        ref_r[g] <= 1'b0;
        hitd_r <= 1'b0;
      end else begin
        div_r <= div_nxt;
        run_r <= run_nxt;
        flt_r[g] <= flt_nxt;
        fltd_r <= flt_r[g];
        pcnt_r <= pcnt_nxt;
        cap_r[g] <= cap_nxt;
        act_r[g] <= act_nxt;
        ref_r[g] <= ref_nxt;
        hitd_r <= counter_value == act_r[g];
      end
    end
  end

  assign rdata = rdata_r;
  assign capture_pulse = {cap_r[1], cap_r[0]};
  assign filtered_input = {flt_r[1], flt_r[0]};
  assign output_reference = {ref_r[1], ref_r[0]};
  assign fast_enable = {mode_r[S+tmc_pkg::FEN_BIT], mode_r[tmc_pkg::FEN_BIT]};
  assign channel_enable = en_r;

  // checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  logic mode_wr;
  assign mode_wr = bus_req.wr && bus_req.addr == tmc_pkg::OFS_MODE;

  AST_SEL1_LOCK: assert property (mode_wr && en_r[0] |=>
    $stable(mode_r[1:0])) else $error("ch1 direction changed while enabled");
  AST_SEL2_LOCK: assert property (mode_wr && en_r[1] |=>
    $stable(mode_r[9:8])) else $error("ch2 direction changed while enabled");
  AST_SEL1_TAKE: assert property (mode_wr && !en_r[0] |=>
    mode_r[1:0] == $past(bus_req.wdata[1:0]))
    else $error("ch1 direction write lost");
  AST_NOFILT: assert property (mode_r[7:4] == 4'h0
    && mode_r[1:0] == 2'h1 && $stable(mode_r) |=> filtered_input[0]
    == $past(timer_input_one)) else $error("unfiltered ch1 not sampled");
  AST_FLT_TICK: assert property ($changed(flt_r[0]) |->
    $past(tick[0])) else $error("ch1 filter moved off a sample tick");
  AST_PSC1: assert property (capture_pulse[0] |->
    $past(en_r[0]) && $past(mode_r[1:0]) != 2'h0)
    else $error("ch1 capture while disabled or output");
  AST_PRELOAD_OFF: assert property (wr_cmp[0] && !mode_r[3]
    && mode_r[1:0] == 2'h0 && !cap_r[0] |=>
    act_r[0] == $past(bus_req.wdata[CNT_W-1:0]))
    else $error("compare not applied at once");
  AST_PRELOAD_ON: assert property (wr_cmp[0] && mode_r[3]
    && !update_event && mode_r[1:0] == 2'h0 |=> $stable(act_r[0]))
    else $error("preloaded compare applied early");
  AST_FORCE_LOW: assert property (mode_r[1:0] == 2'h0
    && mode_r[6:4] == 3'h4 |=> !output_reference[0])
    else $error("forced low not low");
  AST_PWM1: assert property (mode_r[1:0] == 2'h0 && mode_r[6:4] == 3'h6
    && counter_value < act_r[0] |=> output_reference[0])
    else $error("pwm1 not high below compare");
  AST_SEL2_TAKE: assert property (mode_wr && !en_r[1] |=>
    mode_r[9:8] == $past(bus_req.wdata[9:8]))
    else $error("ch2 direction write lost");
  AST_RSV2: assert property (mode_r[9:8] == 2'h0 |-> !mode_r[15])
    else $error("ch2 reserved bit set in output mode");
  AST_PSC2: assert property (capture_pulse[1] |->
    $past(en_r[1]) && $past(mode_r[9:8]) != 2'h0)
    else $error("ch2 capture while disabled or output");
  AST_CMP_UPD: assert property (update_event && mode_r[3]
    && mode_r[1:0] == 2'h0 && !wr_cmp[0] |=> act_r[0] == $past(shd_r[0]))
    else $error("preloaded compare not applied on update");

  COV_CAP8: cover property (capture_pulse[0] && mode_r[3:2] == 2'h3);
  COV_UPD: cover property (mode_r[3] && update_event && mode_r[1:0] == 2'h0);
  COV_LOCK: cover property (mode_wr && en_r[1]);
  COV_PWM2: cover property (mode_r[14:12] == 3'h7 && output_reference[1]);
  COV_SWAP2: cover property (mode_r[9:8] == 2'h2 && filtered_input[1]);
endmodule : tmc_ch12_mode
`default_nettype wire

//--- verif/tmc_pin_model.sv
// model of the channel pins and the internal trigger source
`default_nettype none
module tmc_pin_model (
  input wire logic sys_clk,
  input wire logic [2:0] lvl,
  output logic pin_one,
  output logic pin_two,
  output logic trig
);
  timeunit 1ns;
  timeprecision 1ps;
  // levels follow the request one clock later, like a synchronised pad
  always_ff @(posedge sys_clk) begin
    pin_one <= lvl[0];
    pin_two <= lvl[1];
    trig <= lvl[2];
  end
endmodule : tmc_pin_model
`default_nettype wire

//--- verif/tmc_ch12_mode_test.sv
// self-checking bench for the channel 1/2 mode block
`default_nettype none
`define CHK(nm, e, s) begin checks_done++; if ((s) !== (e)) begin \
  failures++; $display("ERROR %s exp %0h got %0h", nm, e, s); end end
module tmc_ch12_mode_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  tmc_pkg::tmc_bus_req_t bus_req = '0;
  logic [15:0] rdata, d;
  logic [15:0] cnt = 16'h0000;
  logic [2:0] lvl = 3'h0;
  logic pin1, pin2, trig, seen;
  logic upd = 1'b0;
  logic [1:0] cap, filt, oref, fen, cen;
  int failures = 0, checks_done = 0, caps = 0, ch = 0, c;
  int dv[16] = '{1,1,1,1,2,2,4,4,8,8,16,16,16,32,32,32};
  int nn[16] = '{1,2,4,8,6,8,6,8,6,8,5,6,8,5,6,8};
  int s1[4] = '{3,0,1,2};
  int s2[4] = '{3,1,0,2};
  int om[9] = '{1,2,3,0,4,5,6,7,7};
  int oc[9] = '{16,16,16,16,16,16,5,5,32};
  int oe[9] = '{1,0,1,1,0,1,1,0,1};

  tmc_pin_model i_tmc_pin_model (.sys_clk(sys_clk), .lvl(lvl),
    .pin_one(pin1), .pin_two(pin2), .trig(trig));
  tmc_ch12_mode #(.CNT_W(16)) i_tmc_ch12_mode (.sys_clk(sys_clk),
    .reset_n(reset_n), .bus_req(bus_req), .rdata(rdata),
    .timer_input_one(pin1), .timer_input_two(pin2),
    .internal_trigger_selection(trig), .update_event(upd),
    .counter_value(cnt), .capture_pulse(cap), .filtered_input(filt),
    .output_reference(oref), .fast_enable(fen), .channel_enable(cen));

  initial begin
    forever #4 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (cap[ch] === 1'b1) caps <= caps + 1;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [15:0] w);
    @(posedge sys_clk);
    bus_req <= '{addr: a, wdata: w, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    bus_req <= '0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    bus_req <= '0;
    @(posedge sys_clk);
    d = rdata;
  endtask : rd
  task automatic wf(input logic t);
    c = 0;
    while (filt[ch] !== t && c < 400) begin
      @(posedge sys_clk);
      c++;
    end
  endtask : wf
  task automatic pscl(input int k, input logic [1:0] p);
    logic [7:0] f;
    f = {4'h0, p, 2'b01};
    ch = k;
    wr(8'h20, 16'h0000);
    wr(8'h18, k ? {f, 8'h00} : {8'h00, f});
    wr(8'h20, k ? 16'h0010 : 16'h0001);
    caps = 0;
    repeat (16) begin
      lvl[k] <= 1'b1;
      cyc(3);
      lvl[k] <= 1'b0;
      cyc(3);
    end
    `CHK("caps", 16 >> p, caps)
    rd(k ? 8'h38 : 8'h34);
    `CHK("cap_val", 16'h1234, d)
  endtask : pscl
  task automatic test_done;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done

  initial begin
    repeat (40000) @(posedge sys_clk);
    failures++;
    test_done;
  end

  initial begin
    cyc(6);
    reset_n <= 1'b1;
    rd(8'h18);
    `CHK("mode_rst", 16'h0000, d)
    rd(8'h44);
    `CHK("unmapped", 16'h0000, d)
    cnt <= 16'h1234;
    for (int p = 0; p < 4; p++) pscl(0, p[1:0]);
    for (int p = 0; p < 4; p++) pscl(1, p[1:0]);
    ch = 0;
    wr(8'h20, 16'h0000);
    for (int k = 0; k < 16; k++) begin
      wr(8'h18, {8'h00, k[3:0], 4'h1});
      lvl[0] <= 1'b0;
      wf(1'b0);
      lvl[0] <= 1'b1;
      wf(1'b1);
      `CHK("flt", 1'b1, c >= (nn[k]-1)*dv[k] && c <= nn[k]*dv[k]+3)
    end
    // short pulse against 8 equal samples must be dropped
    wr(8'h18, 16'h0031);
    lvl[0] <= 1'b0;
    wf(1'b0);
    lvl[0] <= 1'b1;
    cyc(4);
    lvl[0] <= 1'b0;
    seen = 1'b0;
    repeat (12) begin
      @(posedge sys_clk);
      seen = seen | filt[0];
    end
    `CHK("glitch", 1'b0, seen)
    for (int k = 0; k < 4; k++) begin
      wr(8'h18, {6'h00, k[1:0], 6'h00, k[1:0]});
      for (int s = 0; s < 3; s++) begin
        lvl <= 3'h1 << s;
        cyc(4);
        `CHK("src", {s2[k] == s, s1[k] == s}, filt)
      end
    end
    lvl <= 3'h0;
    wr(8'h20, 16'h0011);
    wr(8'h18, 16'h0000);
    rd(8'h18);
    `CHK("dir_lock", 16'h0303, d)
    `CHK("cen", 2'b11, cen)
    wr(8'h20, 16'h0000);
    wr(8'h18, 16'hFC00);
    rd(8'h18);
    `CHK("ch2_out", 16'h7C00, d)
    `CHK("fen", 2'b10, fen)
    wr(8'h18, 16'h0000);
    wr(8'h34, 16'h0010);
    for (int k = 0; k < 9; k++) begin
      wr(8'h18, {9'h000, om[k][2:0], 4'h0});
      cnt <= 16'h0000;
      cyc(2);
      cnt <= oc[k][15:0];
      cyc(3);
      `CHK("oref", oe[k][0], oref[0])
    end
    wr(8'h18, 16'h0008);
    wr(8'h34, 16'h0055);
    rd(8'h34);
    `CHK("cmp_hold", 16'h0010, d)
    upd <= 1'b1;
    cyc(1);
    upd <= 1'b0;
    rd(8'h34);
    `CHK("cmp_upd", 16'h0055, d)
    wr(8'h18, 16'h0000);
    wr(8'h34, 16'h0077);
    rd(8'h34);
    `CHK("cmp_now", 16'h0077, d)
    wr(8'h18, 16'h5000);
    rd(8'h3C);
    `CHK("oref2", 1'b1, oref[1])
    `CHK("status", 16'h000C, d)
    test_done;
  end
endmodule : tmc_ch12_mode_test
`default_nettype wire
